// [include/pfc_pkg.sv]
// Purpose: Shared constants and carriers for the protection and translation fault checker
// Assumes: Single core clock domain
// Notes: Selector and error-code layouts follow the usual protected-mode formats
package pfc_pkg;
    localparam logic [7:0] VEC_PROT = 8'h0D;
    localparam logic [7:0] VEC_XLAT = 8'h0E;
    localparam logic [7:0] VEC_FLT = 8'h10;
    localparam logic [1:0] PRIV_KERNEL = 2'h0;
    localparam int SEL_TI_BIT = 2;
    localparam int SEL_IDX_LSB = 3;
    localparam int NUM_FERR = 6;
    localparam int PFE_RESIDENT = 0;
    localparam int PFE_WRITE = 1;
    localparam int PFE_USER = 2;
    localparam int PFE_RESERVED_VIOLATION_BIT = 3;
    localparam logic [3:0] GT_TASK = 4'h5;
    localparam logic [3:0] GT_INT = 4'hE;
    localparam logic [3:0] GT_TRAP = 4'hF;
    localparam logic [3:0] GT_CALL = 4'hC;
    localparam logic [3:0] DT_LDT = 4'h2;
    localparam logic [3:0] DT_TSS_AVAIL = 4'h9;

    typedef struct packed {
        logic ctl_wr;         // Write to a control register
        logic [1:0] ctl_sel;  // 0 primary, 1 page-base, 2 extended
        logic no_writethrough_flag;
        logic cache_disable_flag;
        logic ext_reserved_violation_bit_one;   // Reserved bit of extended reg written as 1
        logic msr_reserved_violation_bit_wr;    // Reserved bit of model-specific reg written
        logic pdpt_reload;    // Write reloads page-directory-pointer entries
        logic pdpt_reserved_violation_bit_one;  // Reserved bit of a reloaded entry is 1
        logic priv_instr;
        logic gate_ref;       // Gate descriptor referenced
        logic gate_from_int;  // Reached through interrupt vector table
        logic gate_from_swi;  // Reached by software_interrupt_instr
        logic [3:0] gate_type;
        logic [1:0] gate_dpl;
        logic [15:0] gate_sel;
        logic gate_tgt_code;  // Gate selector names a code segment
        logic xfer;           // Call, jump or return
        logic [15:0] xfer_sel;
        logic load_local_table_instr;
        logic load_task_reg_instr;
        logic [15:0] op_sel;
        logic [3:0] op_desc_type;
        logic gen_viol;       // Any other segment-level violation
        logic [15:0] gen_sel;
        logic gen_sel_valid;
        logic [31:0] instr_ptr;
        logic [15:0] code_seg_sel;
    } pfc_instr_s;

    typedef struct packed {
        logic req;
        logic not_resident;
        logic priv_viol;
        logic rw_viol;        // Violation is a read/write violation
        logic reserved_violation_bit_dir;
        logic write;
        logic user;
        logic in_task_switch; // Fault while reading new task state or table
        logic [31:0] lin_addr;
    } pfc_xlat_s;

    typedef struct packed {
        logic valid;
        logic [7:0] vector;
        logic has_code;
        logic [31:0] err_code;
        logic [15:0] code_seg_sel;
        logic [31:0] instr_ptr;
        logic load_new_task;
    } pfc_exc_s;
endpackage : pfc_pkg

// [core/pfc_checker.sv]
// Purpose: Detects protection, translation and float-error exceptions
// Assumes: Inputs synchronous to SYS_CLK; one check request per cycle
// Notes: Exceptions are reported one cycle after the check request
//
// Overview of operation
// - Loading primary control with no_writethrough set, cache_disable clear faults.
// - Vector table entry not interrupt, trap or task gate faults.
// - Virtual-8086 entry through int or trap gate with privilege above 0 faults.
// - Writing 1 to reserved extended-control bit, or reserved MODEL_SPECIFIC_REGISTER bit, faults.
// - Privileged instruction at current privilege other than 0 faults.
// - Accessing a gate with null selector faults.
// - Software interrupt with current privilege above gate privilege faults.
// - Call, interrupt or trap gate selector not naming code segment faults.
// - Bad local-table or task-register load operand faults.
// - Call, jump or return to a null code selector faults.
// - With extended addressing, reserved pointer-table bits set on reload fault.
// - Protection fault pushes faulting selector, otherwise zero.
// - Protection fault saves pointer to the unexecuted faulting instruction.
// - Task-switch fault before commit keeps state; after commit loads new task.
// - With paging on, not-resident or privilege violation raises translation fault.
// - Translation code holds resident, write and user bits.
// - Reserved directory bits with large-page or extended addressing set reserved bit.
// - Every translation fault loads fault address with the linear address.
// - Protection violation sets directory accessed/dirty; table accessed conditionally.
// - Translation fault reading new task state reports in new task context.
// - Float error exception only while numeric_error_enable is set.
// - Six error flags and masks; masked errors continue without exception.
// - Unmasked error sets flag, waits for waiting instruction, then raises.
// - Protection fault catches violations not given a more specific fault.
`timescale 1ns/1ps
module pfc_checker #(
    parameter int NFE = pfc_pkg::NUM_FERR
) (
    input wire logic SYS_CLK,                        // Core clock
    input wire logic RESET_N,                        // Async reset, active low
    input wire logic INSTR_REQ,                      // Instruction check request
    input wire pfc_pkg::pfc_instr_s INSTR,           // Instruction check details
    input wire logic [1:0] CURRENT_PRIVILEGE,        // Current privilege level
    input wire logic V86_MODE,                       // Virtual-8086 mode active
    input wire logic EXTENDED_PHYS_ADDR_FLAG,        // Extended addressing on
    input wire logic LARGE_PAGE_FLAG,                // Large pages on
    input wire logic PAGING_ENABLE_FLAG,             // Paging on
    input wire logic NUMERIC_ERROR_ENABLE,           // Float errors raise exception
    input wire logic SPECIFIC_FAULT,                 // More specific fault claims it
    input wire logic TASK_SWITCH,                    // Task switch in progress
    input wire logic TASK_COMMITTED,                 // Commit point passed
    input wire pfc_pkg::pfc_xlat_s XLAT,             // Translation check
    input wire logic [31:0] NEW_TASK_IP,             // New task first instruction
    input wire logic [15:0] NEW_TASK_CS,             // New task code selector
    input wire logic [NFE-1:0] FERR_DETECT,          // Float errors detected
    input wire logic [NFE-1:0] FERR_MASK,            // Float error masks
    input wire logic WAITING_INSTR,                  // Waiting float or wait instr
    input wire logic FERR_CLEAR,                     // Clear float status flags
    output pfc_pkg::pfc_exc_s EXC,                   // Exception to vector
    output logic [31:0] FAULT_ADDRESS_REGISTER,      // Last faulting linear address
    output logic DIR_ACCESSED_SET,                   // Set directory accessed flag
    output logic DIR_DIRTY_SET,                      // Set directory dirty flag
    output logic TABLE_ACCESSED_SET,                 // Set table accessed flag
    output logic [NFE-1:0] FERR_STATUS,              // Float error status flags
    output logic FERR_DEFAULT                        // Masked error default response
);
    ////////////////////////////////////////////////////////////////////////////
    logic prot_hit;
    logic [15:0] prot_sel;
    logic null_gate;
    logic gate_bad_type;
    logic xlat_hit;
    logic [31:0] xlat_code;
    logic [NFE-1:0] unmasked;
    logic ferr_pending_r;
    logic ferr_pending_nxt;
    logic ferr_fire;

    function automatic logic sel_null(input logic [15:0] s);
        sel_null = (s[15:pfc_pkg::SEL_IDX_LSB] == 13'h0000);
    endfunction : sel_null

    ////////////////////////////////////////////////////////////////////////////
    // Protection checks
    always_comb begin
        null_gate = INSTR.gate_ref && sel_null(INSTR.gate_sel);
        gate_bad_type = INSTR.gate_from_int
            && (INSTR.gate_type != pfc_pkg::GT_INT)
            && (INSTR.gate_type != pfc_pkg::GT_TRAP)
            && (INSTR.gate_type != pfc_pkg::GT_TASK);
        prot_hit = 1'b0;
        prot_sel = 16'h0000;
        if (INSTR.ctl_wr && INSTR.ctl_sel == 2'h0 && INSTR.no_writethrough_flag
            && !INSTR.cache_disable_flag)
            prot_hit = 1'b1;
        if (INSTR.ext_reserved_violation_bit_one || INSTR.msr_reserved_violation_bit_wr)
            prot_hit = 1'b1;
        if (INSTR.priv_instr && CURRENT_PRIVILEGE != pfc_pkg::PRIV_KERNEL)
            prot_hit = 1'b1;
        if (EXTENDED_PHYS_ADDR_FLAG && INSTR.ctl_wr && INSTR.pdpt_reload
            && INSTR.pdpt_reserved_violation_bit_one)
            prot_hit = 1'b1;
        if (INSTR.gen_viol) begin
            prot_hit = 1'b1;
            prot_sel = INSTR.gen_sel_valid ? INSTR.gen_sel : 16'h0000;
        end
        if (INSTR.xfer && sel_null(INSTR.xfer_sel))
            prot_hit = 1'b1;
        if (INSTR.load_local_table_instr && (INSTR.op_sel[pfc_pkg::SEL_TI_BIT]
            || INSTR.op_desc_type != pfc_pkg::DT_LDT)) begin
            prot_hit = 1'b1;
            prot_sel = INSTR.op_sel;
        end
        if (INSTR.load_task_reg_instr && (INSTR.op_sel[pfc_pkg::SEL_TI_BIT]
            || INSTR.op_desc_type != pfc_pkg::DT_TSS_AVAIL)) begin
            prot_hit = 1'b1;
            prot_sel = INSTR.op_sel;
        end
        if (INSTR.gate_ref) begin
            if (gate_bad_type || null_gate
                || (INSTR.gate_from_swi && CURRENT_PRIVILEGE > INSTR.gate_dpl)
                || (V86_MODE && INSTR.gate_from_int && INSTR.gate_dpl != pfc_pkg::PRIV_KERNEL
                    && (INSTR.gate_type == pfc_pkg::GT_INT
                        || INSTR.gate_type == pfc_pkg::GT_TRAP))
                || (!null_gate && !INSTR.gate_tgt_code
                    && (INSTR.gate_type == pfc_pkg::GT_CALL
                        || INSTR.gate_type == pfc_pkg::GT_INT
                        || INSTR.gate_type == pfc_pkg::GT_TRAP))) begin
                prot_hit = 1'b1;
                prot_sel = INSTR.gate_sel;
            end
        end
        prot_hit = prot_hit && INSTR_REQ && !SPECIFIC_FAULT;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Translation checks
    always_comb begin
        xlat_hit = XLAT.req && PAGING_ENABLE_FLAG
            && (XLAT.not_resident || XLAT.priv_viol
                || (XLAT.reserved_violation_bit_dir && (LARGE_PAGE_FLAG || EXTENDED_PHYS_ADDR_FLAG)));
        xlat_code = 32'h0000_0000;
        xlat_code[pfc_pkg::PFE_RESIDENT] = !XLAT.not_resident;
        xlat_code[pfc_pkg::PFE_WRITE] = XLAT.write;
        xlat_code[pfc_pkg::PFE_USER] = XLAT.user;
        xlat_code[pfc_pkg::PFE_RESERVED_VIOLATION_BIT] = XLAT.reserved_violation_bit_dir
            && (LARGE_PAGE_FLAG || EXTENDED_PHYS_ADDR_FLAG);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Float error gating
    assign unmasked = FERR_DETECT & ~FERR_MASK;
    assign ferr_fire = ferr_pending_r && WAITING_INSTR && NUMERIC_ERROR_ENABLE;
    // A fire that loses to a translation or protection fault stays pending
    assign ferr_pending_nxt = ((|unmasked) && NUMERIC_ERROR_ENABLE)
        || (ferr_pending_r && !(ferr_fire && !xlat_hit && !prot_hit) && !FERR_CLEAR);

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            FERR_STATUS <= '0;
        end else begin
            // Set wins over clear
            FERR_STATUS <= (FERR_CLEAR ? '0 : FERR_STATUS) | FERR_DETECT;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ferr_pending_r <= 1'b0;
            FERR_DEFAULT <= 1'b0;
        end else begin
            ferr_pending_r <= ferr_pending_nxt;
            FERR_DEFAULT <= |(FERR_DETECT & FERR_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Accessed/dirty updates and fault address
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            FAULT_ADDRESS_REGISTER <= 32'h0000_0000;
            DIR_ACCESSED_SET <= 1'b0;
            DIR_DIRTY_SET <= 1'b0;
            TABLE_ACCESSED_SET <= 1'b0;
        end else begin
            if (xlat_hit)
                FAULT_ADDRESS_REGISTER <= XLAT.lin_addr;
            DIR_ACCESSED_SET <= xlat_hit && XLAT.priv_viol;
            DIR_DIRTY_SET <= xlat_hit && XLAT.priv_viol;
            TABLE_ACCESSED_SET <= XLAT.req && PAGING_ENABLE_FLAG && !XLAT.not_resident
                && (!XLAT.priv_viol || XLAT.rw_viol);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Exception report; translation outranks protection, then float error
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            EXC <= '0;
        end else begin
            EXC <= '0;
            if (xlat_hit) begin
                EXC.valid <= 1'b1;
                EXC.vector <= pfc_pkg::VEC_XLAT;
                EXC.has_code <= 1'b1;
                EXC.err_code <= xlat_code;
                if (XLAT.in_task_switch) begin
                    EXC.code_seg_sel <= NEW_TASK_CS;
                    EXC.instr_ptr <= NEW_TASK_IP;
                    EXC.load_new_task <= 1'b1;
                end else begin
                    EXC.code_seg_sel <= INSTR.code_seg_sel;
                    EXC.instr_ptr <= INSTR.instr_ptr;
                    EXC.load_new_task <= TASK_SWITCH && TASK_COMMITTED;
                end
            end else if (prot_hit) begin
                EXC.valid <= 1'b1;
                EXC.vector <= pfc_pkg::VEC_PROT;
                EXC.has_code <= 1'b1;
                EXC.err_code <= {16'h0000, prot_sel};
                // Faulting instruction not executed, so restartable
                EXC.code_seg_sel <= TASK_SWITCH && TASK_COMMITTED
                    ? NEW_TASK_CS : INSTR.code_seg_sel;
                EXC.instr_ptr <= TASK_SWITCH && TASK_COMMITTED
                    ? NEW_TASK_IP : INSTR.instr_ptr;
                EXC.load_new_task <= TASK_SWITCH && TASK_COMMITTED;
            end else if (ferr_fire) begin
                EXC.valid <= 1'b1;
                EXC.vector <= pfc_pkg::VEC_FLT;
                EXC.code_seg_sel <= INSTR.code_seg_sel;
                EXC.instr_ptr <= INSTR.instr_ptr;
            end
        end
    end
endmodule : pfc_checker

// [dv/pfc_checker_sva.sv]
// Purpose: Port-level assertions for the fault checker
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound into every pfc_checker instance
`timescale 1ns/1ps
module pfc_checker_sva #(
    parameter int NFE = pfc_pkg::NUM_FERR
) (
    input wire logic SYS_CLK, // Clock
    input wire logic RESET_N, // Reset
    input wire logic INSTR_REQ, // Check request
    input wire pfc_pkg::pfc_instr_s INSTR, // Details
    input wire logic [1:0] CURRENT_PRIVILEGE, // Privilege
    input wire logic SPECIFIC_FAULT, // Suppress
    input wire pfc_pkg::pfc_xlat_s XLAT, // Translation
    input wire logic PAGING_ENABLE_FLAG, // Paging
    input wire logic LARGE_PAGE_FLAG, // Large pages
    input wire logic EXTENDED_PHYS_ADDR_FLAG, // Extended addressing
    input wire logic NUMERIC_ERROR_ENABLE, // Float enable
    input wire logic WAITING_INSTR, // Waiting instr
    input wire logic [NFE-1:0] FERR_DETECT, // Errors
    input wire logic [NFE-1:0] FERR_MASK, // Masks
    input wire logic [NFE-1:0] FERR_STATUS, // Flags
    input wire pfc_pkg::pfc_exc_s EXC, // Exception
    input wire logic [31:0] FAULT_ADDRESS_REGISTER, // Address
    input wire logic DIR_ACCESSED_SET, // Dir accessed
    input wire logic DIR_DIRTY_SET, // Dir dirty
    input wire logic FERR_DEFAULT // Masked seen
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    logic xf;
    logic pf_ok;
    logic [NFE-1:0] unm;
    // Translation outranks protection in the same cycle
    assign xf = XLAT.req && PAGING_ENABLE_FLAG && (XLAT.not_resident || XLAT.priv_viol
        || (XLAT.reserved_violation_bit_dir && (LARGE_PAGE_FLAG || EXTENDED_PHYS_ADDR_FLAG)));
    assign pf_ok = INSTR_REQ && !SPECIFIC_FAULT && !xf;
    assign unm = FERR_DETECT & ~FERR_MASK;
    sequence s_xfault;
        xf;
    endsequence
    sequence s_unmasked;
        NUMERIC_ERROR_ENABLE && (unm != '0);
    endsequence
    property p_prot(c);
        pf_ok && c |=> EXC.valid && EXC.vector == pfc_pkg::VEC_PROT;
    endproperty
    chk_priv_instr: assert property (p_prot(INSTR.priv_instr && CURRENT_PRIVILEGE != 2'h0))
        else $error("privileged instruction not faulted");
    chk_null_gate: assert property (p_prot(INSTR.gate_ref && INSTR.gate_sel[15:3] == 13'h0))
        else $error("null gate not faulted");
    chk_null_target: assert property (p_prot(INSTR.xfer && INSTR.xfer_sel[15:3] == 13'h0))
        else $error("null target not faulted");
    chk_xlat_vector: assert property (s_xfault |=> EXC.valid && EXC.vector == pfc_pkg::VEC_XLAT)
        else $error("translation fault missing");
    chk_fault_addr: assert property (s_xfault |=> FAULT_ADDRESS_REGISTER == $past(XLAT.lin_addr))
        else $error("fault address not loaded");
    chk_xlat_code: assert property (s_xfault |=> EXC.err_code[2:0] ==
        {$past(XLAT.user), $past(XLAT.write), !$past(XLAT.not_resident)})
        else $error("translation code wrong");
    chk_dir_flags: assert property (xf && XLAT.priv_viol && !XLAT.not_resident
        |=> DIR_ACCESSED_SET && DIR_DIRTY_SET) else $error("directory flags not set");
    chk_float_gate: assert property (EXC.valid && EXC.vector == pfc_pkg::VEC_FLT
        |-> $past(WAITING_INSTR) && $past(NUMERIC_ERROR_ENABLE)) else $error("float fire ungated");
    chk_float_flag: assert property (s_unmasked |=> (FERR_STATUS & $past(unm)) == $past(unm))
        else $error("float flag not set");
    chk_masked_dflt: assert property ((FERR_DETECT & FERR_MASK) != '0 |=> FERR_DEFAULT)
        else $error("masked default missing");
endmodule : pfc_checker_sva
bind pfc_checker pfc_checker_sva #(.NFE(NFE)) u_sva (.*);

// [dv/pfc_checker_test.sv]
// Purpose: Self-checking bench for the fault checker
// Assumes: Inputs driven by NBA at the rising edge, except float mask and enable changes that follow an fl call, driven 1 ns after it
// Notes: Each scenario task judges the outputs it causes
`timescale 1ns/1ps
module pfc_checker_test;
    logic SYS_CLK = 1'b0, RESET_N = 1'b0, INSTR_REQ = 1'b0, V86_MODE = 1'b0, FERR_CLEAR = 1'b0;
    logic EXTENDED_PHYS_ADDR_FLAG = 1'b0, LARGE_PAGE_FLAG = 1'b0, PAGING_ENABLE_FLAG = 1'b0;
    logic NUMERIC_ERROR_ENABLE = 1'b0, SPECIFIC_FAULT = 1'b0, WAITING_INSTR = 1'b0;
    logic TASK_SWITCH = 1'b0, TASK_COMMITTED = 1'b0;
    logic [1:0] CURRENT_PRIVILEGE = 2'h0;
    logic [15:0] NEW_TASK_CS = 16'h0;
    logic [31:0] NEW_TASK_IP = 32'h0, ip = 32'h1000, last_fa = 32'h0;
    logic [5:0] FERR_DETECT = 6'h00, FERR_MASK = 6'h00;
    pfc_pkg::pfc_instr_s INSTR = '0;
    pfc_pkg::pfc_xlat_s XLAT = '0;
    logic DIR_ACCESSED_SET, DIR_DIRTY_SET, TABLE_ACCESSED_SET, FERR_DEFAULT;
    logic [5:0] FERR_STATUS;
    logic [31:0] FAULT_ADDRESS_REGISTER;
    pfc_pkg::pfc_exc_s EXC;
    int failures = 0, num_checks = 0;
    always #2.5 SYS_CLK = ~SYS_CLK;
    pfc_checker dut (.*);
    ////////////////////////////////////////
    task check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task summarize;
        if (failures == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    task prot(input pfc_pkg::pfc_instr_s i, input logic [1:0] current_privilege, input logic f,
        input logic [15:0] sel);
        logic nt;
        ip = ip + 32'h4;
        i.instr_ptr = ip;
        i.code_seg_sel = 16'h0008;
        @(posedge SYS_CLK);
        INSTR <= i;
        INSTR_REQ <= 1'b1;
        CURRENT_PRIVILEGE <= current_privilege;
        // Task-switch levels read after their own edge has landed
        nt = TASK_SWITCH && TASK_COMMITTED;
        @(posedge SYS_CLK);
        INSTR_REQ <= 1'b0;
        #1;
        check(EXC.valid, f);
        if (f) begin
            check(EXC.vector, pfc_pkg::VEC_PROT);
            check(EXC.err_code, {16'h0, sel});
            check(EXC.instr_ptr, nt ? NEW_TASK_IP : ip);
            check(EXC.code_seg_sel, nt ? NEW_TASK_CS : 16'h0008);
            check(EXC.load_new_task, nt);
        end
    endtask : prot
    task xl(input pfc_pkg::pfc_xlat_s x, input logic f, input logic [3:0] code,
        input logic dir, input logic tab);
        @(posedge SYS_CLK);
        XLAT <= x;
        @(posedge SYS_CLK);
        XLAT <= '0;
        #1;
        if (f) last_fa = x.lin_addr;
        check(EXC.valid, f);
        check(FAULT_ADDRESS_REGISTER, last_fa);
        check({DIR_ACCESSED_SET, DIR_DIRTY_SET, TABLE_ACCESSED_SET}, {dir, dir, tab});
        if (f) check(EXC.err_code, {28'h0, code});
        if (x.in_task_switch) check(EXC.instr_ptr, NEW_TASK_IP);
    endtask : xl
    task fl(input logic [5:0] det, input logic wt, input logic fire);
        @(posedge SYS_CLK);
        FERR_DETECT <= det;
        @(posedge SYS_CLK);
        FERR_DETECT <= 6'h00;
        WAITING_INSTR <= wt;
        #1;
        check(FERR_DEFAULT, |(det & FERR_MASK));
        @(posedge SYS_CLK);
        WAITING_INSTR <= 1'b0;
        #1;
        check(EXC.valid, fire);
        if (fire) check({EXC.vector, EXC.has_code}, {pfc_pkg::VEC_FLT, 1'b0});
    endtask : fl
    ////////////////////////////////////////
    task t_control;
        pfc_pkg::pfc_instr_s c;
        c = '{ctl_wr:'1, no_writethrough_flag:'1, default:'0};
        prot(c, 2'h0, 1'b1, 16'h0);
        c.cache_disable_flag = 1'b1;
        prot(c, 2'h0, 1'b0, 16'h0);
        prot('{ctl_wr:'1, ctl_sel:2'h2, ext_reserved_violation_bit_one:'1, default:'0}, 2'h0, 1'b1, 16'h0);
        prot('{msr_reserved_violation_bit_wr:'1, default:'0}, 2'h0, 1'b1, 16'h0);
        c = '{ctl_wr:'1, ctl_sel:2'h1, pdpt_reload:'1, pdpt_reserved_violation_bit_one:'1, default:'0};
        prot(c, 2'h0, 1'b0, 16'h0);
        @(posedge SYS_CLK);
        EXTENDED_PHYS_ADDR_FLAG <= 1'b1;
        prot(c, 2'h0, 1'b1, 16'h0);
    endtask : t_control
    task t_gates;
        pfc_pkg::pfc_instr_s g;
        g = '{gate_ref:'1, gate_from_int:'1, gate_type:pfc_pkg::GT_CALL, gate_sel:16'h0010,
            gate_tgt_code:'1, default:'0};
        prot(g, 2'h0, 1'b1, 16'h0010);
        g.gate_type = pfc_pkg::GT_TASK;
        prot(g, 2'h0, 1'b0, 16'h0);
        g.gate_type = pfc_pkg::GT_TRAP;
        g.gate_dpl = 2'h3;
        @(posedge SYS_CLK);
        V86_MODE <= 1'b1;
        prot(g, 2'h0, 1'b1, 16'h0010);
        g.gate_dpl = 2'h0;
        prot(g, 2'h0, 1'b0, 16'h0);
        @(posedge SYS_CLK);
        V86_MODE <= 1'b0;
        g.gate_from_int = 1'b0;
        g.gate_from_swi = 1'b1;
        prot(g, 2'h3, 1'b1, 16'h0010);
        g.gate_dpl = 2'h3;
        prot(g, 2'h3, 1'b0, 16'h0);
        g.gate_tgt_code = 1'b0;
        prot(g, 2'h3, 1'b1, 16'h0010);
        g.gate_tgt_code = 1'b1;
        g.gate_sel = 16'h0;
        prot(g, 2'h3, 1'b1, 16'h0);
    endtask : t_gates
    task t_operands;
        pfc_pkg::pfc_instr_s o;
        o = '{load_local_table_instr:'1, op_sel:16'h0014, op_desc_type:pfc_pkg::DT_LDT, default:'0};
        prot(o, 2'h0, 1'b1, 16'h0014);
        o.op_sel = 16'h0018;
        prot(o, 2'h0, 1'b0, 16'h0);
        o.op_desc_type = pfc_pkg::DT_TSS_AVAIL;
        prot(o, 2'h0, 1'b1, 16'h0018);
        o.load_local_table_instr = 1'b0;
        o.load_task_reg_instr = 1'b1;
        prot(o, 2'h0, 1'b0, 16'h0);
        o.op_desc_type = 4'hB;
        prot(o, 2'h0, 1'b1, 16'h0018);
        prot('{xfer:'1, xfer_sel:16'h0003, default:'0}, 2'h0, 1'b1, 16'h0);
        prot('{priv_instr:'1, default:'0}, 2'h1, 1'b1, 16'h0);
        prot('{priv_instr:'1, default:'0}, 2'h0, 1'b0, 16'h0);
        o = '{gen_viol:'1, gen_sel_valid:'1, gen_sel:16'h0028, default:'0};
        prot(o, 2'h0, 1'b1, 16'h0028);
        @(posedge SYS_CLK);
        SPECIFIC_FAULT <= 1'b1;
        prot(o, 2'h0, 1'b0, 16'h0);
        @(posedge SYS_CLK);
        SPECIFIC_FAULT <= 1'b0;
        TASK_SWITCH <= 1'b1;
        NEW_TASK_IP <= 32'h0000_8000;
        NEW_TASK_CS <= 16'h0030;
        prot('{priv_instr:'1, default:'0}, 2'h3, 1'b1, 16'h0);
        @(posedge SYS_CLK);
        TASK_COMMITTED <= 1'b1;
        prot('{priv_instr:'1, default:'0}, 2'h3, 1'b1, 16'h0);
    endtask : t_operands
    task t_xlat;
        @(posedge SYS_CLK);
        PAGING_ENABLE_FLAG <= 1'b1;
        xl('{req:'1, not_resident:'1, lin_addr:32'h0040_1000, default:'0}, 1'b1, 4'h0, 0, 0);
        xl('{req:'1, not_resident:'1, write:'1, user:'1, lin_addr:32'h7FFF_F004, default:'0},
            1'b1, 4'h6, 1'b0, 1'b0);
        xl('{req:'1, priv_viol:'1, user:'1, lin_addr:32'hC000_0010, default:'0},
            1'b1, 4'h5, 1'b1, 1'b0);
        xl('{req:'1, priv_viol:'1, rw_viol:'1, write:'1, user:'1, lin_addr:32'hC000_2000,
            default:'0}, 1'b1, 4'h7, 1'b1, 1'b1);
        xl('{req:'1, lin_addr:32'h0000_3000, default:'0}, 1'b0, 4'h0, 1'b0, 1'b1);
        xl('{req:'1, priv_viol:'1, reserved_violation_bit_dir:'1, lin_addr:32'h0080_0000, default:'0},
            1'b1, 4'h9, 1'b1, 1'b0);
        xl('{req:'1, not_resident:'1, in_task_switch:'1, lin_addr:32'h0000_5000,
            default:'0}, 1'b1, 4'h0, 1'b0, 1'b0);
        @(posedge SYS_CLK);
        PAGING_ENABLE_FLAG <= 1'b0;
        xl('{req:'1, not_resident:'1, lin_addr:32'h0000_6000, default:'0}, 1'b0, 4'h0, 0, 0);
    endtask : t_xlat
    task t_float;
        @(posedge SYS_CLK);
        NUMERIC_ERROR_ENABLE <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            fl(6'h01 << k, 1'b0, 1'b0);
            check(FERR_STATUS[k], 1'b1);
            fl(6'h00, 1'b1, 1'b1);
            @(posedge SYS_CLK);
            FERR_CLEAR <= 1'b1;
            @(posedge SYS_CLK);
            FERR_CLEAR <= 1'b0;
        end
        FERR_MASK <= 6'h3F;
        fl(6'h3F, 1'b1, 1'b0);
        FERR_MASK <= 6'h00;
        NUMERIC_ERROR_ENABLE <= 1'b0;
        fl(6'h04, 1'b1, 1'b0);
        NUMERIC_ERROR_ENABLE <= 1'b1;
        fl(6'h00, 1'b1, 1'b0);
    endtask : t_float
    ////////////////////////////////////////
    initial begin
        repeat (10) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        t_control;
        t_gates;
        t_operands;
        t_xlat;
        t_float;
        summarize;
    end
    initial begin
        #20000;
        failures++;
        summarize;
    end
endmodule : pfc_checker_test
